/* File: psled_pkg.sv */
// Package: register map, field layout and timing constants for the port status LED driver
package psled_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] PSLED_LED_CONFIG_ADDR = 12'h1BC;
  localparam logic [11:0] PSLED_CONTROL_ADDR    = 12'h1C0;
  localparam logic [11:0] PSLED_STATUS_ADDR     = 12'h1C4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PSLED_EN_LSB     = 0;
  localparam int PSLED_EN_MSB     = 5;
  localparam int PSLED_FUN_LSB    = 8;
  localparam int PSLED_FUN_MSB    = 10;
  localparam int PSLED_DIS_BIT    = 0;
  localparam int PSLED_GPIO_D_LSB = 8;
  localparam int PSLED_GPIO_B_LSB = 16;
  localparam int PSLED_GPIO_O_LSB = 24;

  // ------------------------------------------------------------
  // Function codes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0]  PSLED_FUN_RAW      = 3'h7;
  localparam logic [2:0]  PSLED_FUN_RSVD     = 3'h6;
  localparam logic [31:0] PSLED_CONTROL_RST  = 32'h0000_0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int PSLED_CLK_HZ      = 25_000_000;
  localparam int PSLED_STRETCH_MS  = 80;
  localparam int PSLED_STRETCH_CYC = PSLED_CLK_HZ / 1000 * PSLED_STRETCH_MS;

  typedef enum logic [1:0] {
    PSLED_ST_IDLE    = 2'b00,
    PSLED_ST_PULSE   = 2'b01,
    PSLED_ST_RECOVER = 2'b10
  } psled_stretch_t;

endpackage

/* File: psled_ev_if.sv */
// Interface: one traffic event into a pulse stretcher and its stretched output
`timescale 1ns/1ps
interface psled_ev_if;
  logic event_in;
  logic pulse_out;
  modport src (output event_in, input pulse_out);
  modport str (input event_in, output pulse_out);
endinterface

/* File: psled_stretch.sv */
// Pulse stretcher: fixed active pulse followed by fixed recovery time
`timescale 1ns/1ps
module psled_stretch
  import psled_pkg::*;
#(
  parameter int CYCLES = PSLED_STRETCH_CYC
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  // Event and pulse
  psled_ev_if.str   ev
);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("psled_stretch: CYCLES must be at least 1");
  end

  localparam int CW = $clog2(CYCLES + 1);

  psled_stretch_t state_r;
  logic [CW-1:0]  count_r;

  // ------------------------------------------------------------
  // Pulse, then recovery; events during either are dropped
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_r <= PSLED_ST_IDLE;
      count_r <= '0;
    end else begin
      case (state_r)
        PSLED_ST_IDLE: begin
          if (ev.event_in) begin
            state_r <= PSLED_ST_PULSE;
            count_r <= CW'(CYCLES - 1);
          end
        end
        PSLED_ST_PULSE: begin
          if (count_r == '0) begin
            state_r <= PSLED_ST_RECOVER;
            count_r <= CW'(CYCLES - 1);
          end else begin
            count_r <= count_r - 1'b1;
          end
        end
        PSLED_ST_RECOVER: begin
          if (count_r == '0) begin
            state_r <= PSLED_ST_IDLE;
          end else begin
            count_r <= count_r - 1'b1;
          end
        end
        default: begin
          state_r <= PSLED_ST_IDLE;
          count_r <= '0;
        end
      endcase
    end
  end

  assign ev.pulse_out = (state_r == PSLED_ST_PULSE);

endmodule

/* File: psled_top.sv */
// Top: port status LED driver for six shared GPIO/LED pins behind AHB-Lite
`timescale 1ns/1ps

// What this block does
// - Active level is inverse of hard strap
// - Stretched modes show inactive as undriven
// - LED pins disable input buffer and pull-up
// - Transmit pulses 80 ms, recovers 80 ms
// - Receive pulses 80 ms, ignores link
// - Activity idles inactive, pulses 80 ms
// - Activity gated by link, or passed ungated with external MII
// - Link steady active with valid link
// - Link/activity pulses inactive on traffic
// - Fast link active only at 100 Mbps
// - Fast link/activity blinks off on traffic
// - Slow link active only at 10 Mbps
// - Slow link/activity blinks off on traffic
// - Duplex steady, collisions pulse in half duplex
// - Speed active at 100, inactive otherwise
// - Code 111b uses push-pull true polarity
// - Code 111b passes raw transmit/receive signals
// - Enable bits 5:0 pick GPIO or LED
// - Function bits 10:8 pick pin indications
// - Reset loads function and enable fields from straps, control fields to zero
// - GPIO output follows GPIO settings only
// - Global disable: undriven or push-pull inactive
module psled_top
  import psled_pkg::*;
#(
  parameter int NPORT         = 3,
  parameter int NPIN          = 6,
  parameter int STRETCH_CYCLES = PSLED_STRETCH_CYC
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Configuration straps (held stable through reset)
  input  wire logic [2:0]        i_function_select_strap,
  input  wire logic [NPIN-1:0]   i_pin_enable_strap,
  input  wire logic [NPIN-1:0]   i_polarity_strap,
  // Port status from switch fabric and PHYs
  input  wire logic [NPORT-1:0]  i_link_up,
  input  wire logic [NPORT-1:0]  i_speed_100,
  input  wire logic [NPORT-1:0]  i_full_duplex,
  input  wire logic [NPORT-1:0]  i_collision,
  input  wire logic [NPORT-1:0]  i_tx_en,
  input  wire logic [NPORT-1:0]  i_rx_dv,
  input  wire logic [NPORT-1:0]  i_ext_mii,
  // Shared pins
  output logic      [NPIN-1:0]   o_pin_out,
  output logic      [NPIN-1:0]   o_pin_oe_b,
  output logic      [NPIN-1:0]   o_pin_ibuf_en,
  output logic      [NPIN-1:0]   o_pin_pullup_en
);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (NPORT != 3 || NPIN != 6) begin : g_bad_map
    $error("psled_top: map fixed to 3 ports, 6 pins");
  end
  if (STRETCH_CYCLES < 1) begin : g_bad_cycles
    $error("psled_top: STRETCH_CYCLES must be at least 1");
  end

  // ------------------------------------------------------------
  // Port status input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 7 * NPORT;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_link_up, i_speed_100, i_full_duplex, i_collision,
                  i_tx_en, i_rx_dv, i_ext_mii};
      sync2_r <= sync1_r;
    end
  end

  logic [NPORT-1:0] link;
  logic [NPORT-1:0] spd100;
  logic [NPORT-1:0] fdx;
  logic [NPORT-1:0] coll;
  logic [NPORT-1:0] txen;
  logic [NPORT-1:0] rxdv;
  logic [NPORT-1:0] extm;
  assign {link, spd100, fdx, coll, txen, rxdv, extm} = sync2_r;

  // ------------------------------------------------------------
  // Straps captured after reset release
  // ------------------------------------------------------------
  logic            strap_done_r;
  logic [NPIN-1:0] polarity_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!strap_done_r) begin
      // Hard strap only; no bus write reaches it
      polarity_r <= i_polarity_strap;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [11:0] addr_r;
  logic        acc_ok;

  assign acc_ok = i_hsel && i_hready && i_htrans[1];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
    end else begin
      wr_pend_r <= acc_ok && i_hwrite;
      rd_pend_r <= acc_ok && !i_hwrite;
      if (acc_ok) begin
        addr_r <= {i_haddr[11:2], 2'b00};
      end
    end
  end

  logic [2:0]      fun_r;
  logic [NPIN-1:0] en_r;
  logic            dis_r;
  logic [NPIN-1:0] gpio_data_r;
  logic [NPIN-1:0] gpio_buf_r;
  logic [NPIN-1:0] gpio_oe_r;

  // LED configuration fields, loaded from straps on first clock after reset
  always_ff @(posedge i_sys_clk) begin
    if (!strap_done_r) begin
      fun_r <= i_function_select_strap;
      en_r  <= i_pin_enable_strap;
    end else if (wr_pend_r && addr_r == PSLED_LED_CONFIG_ADDR) begin
      fun_r <= i_hwdata[PSLED_FUN_MSB:PSLED_FUN_LSB];
      en_r  <= i_hwdata[PSLED_EN_MSB:PSLED_EN_LSB];
    end
  end

  // Control: global disable and GPIO output settings
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      dis_r       <= PSLED_CONTROL_RST[PSLED_DIS_BIT];
      gpio_data_r <= '0;
      gpio_buf_r  <= '0;
      gpio_oe_r   <= '0;
    end else if (wr_pend_r && addr_r == PSLED_CONTROL_ADDR) begin
      dis_r       <= i_hwdata[PSLED_DIS_BIT];
      gpio_data_r <= i_hwdata[PSLED_GPIO_D_LSB +: NPIN];
      gpio_buf_r  <= i_hwdata[PSLED_GPIO_B_LSB +: NPIN];
      gpio_oe_r   <= i_hwdata[PSLED_GPIO_O_LSB +: NPIN];
    end
  end

  logic [31:0] rd_data;
  logic [NPIN-1:0] ind;

  always_comb begin
    rd_data = '0;
    case (addr_r)
      PSLED_LED_CONFIG_ADDR: begin
        rd_data[PSLED_FUN_MSB:PSLED_FUN_LSB] = fun_r;
        rd_data[PSLED_EN_MSB:PSLED_EN_LSB]   = en_r;
      end
      PSLED_CONTROL_ADDR: begin
        rd_data[PSLED_DIS_BIT]               = dis_r;
        rd_data[PSLED_GPIO_D_LSB +: NPIN]    = gpio_data_r;
        rd_data[PSLED_GPIO_B_LSB +: NPIN]    = gpio_buf_r;
        rd_data[PSLED_GPIO_O_LSB +: NPIN]    = gpio_oe_r;
      end
      PSLED_STATUS_ADDR: begin
        rd_data[NPIN-1:0]                    = ind;
        rd_data[PSLED_GPIO_D_LSB +: NPIN]    = polarity_r;
      end
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_hrdata    <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      // Reads insert one wait state so the registered data stands when sampled
      o_hreadyout <= !(acc_ok && !i_hwrite);
      o_hresp     <= 1'b0;
      o_hrdata    <= (acc_ok && !i_hwrite) ? 32'h0000_0000 : o_hrdata;
      if (rd_pend_r) begin
        o_hrdata <= rd_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Stretchers: tx, rx, activity, collision per port
  // ------------------------------------------------------------
  logic [NPORT-1:0] tx_p;
  logic [NPORT-1:0] rx_p;
  logic [NPORT-1:0] act_p;
  logic [NPORT-1:0] col_p;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    psled_ev_if tx_if ();
    psled_ev_if rx_if ();
    psled_ev_if act_if ();
    psled_ev_if col_if ();
    assign tx_if.event_in  = txen[p];
    assign rx_if.event_in  = rxdv[p];
    assign act_if.event_in = txen[p] | rxdv[p];
    assign col_if.event_in = coll[p] & ~fdx[p];
    assign tx_p[p]  = tx_if.pulse_out;
    assign rx_p[p]  = rx_if.pulse_out;
    assign act_p[p] = act_if.pulse_out;
    assign col_p[p] = col_if.pulse_out;
    psled_stretch #(.CYCLES(STRETCH_CYCLES)) u_tx (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .ev        (tx_if)
    );
    psled_stretch #(.CYCLES(STRETCH_CYCLES)) u_rx (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .ev        (rx_if)
    );
    psled_stretch #(.CYCLES(STRETCH_CYCLES)) u_act (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .ev        (act_if)
    );
    psled_stretch #(.CYCLES(STRETCH_CYCLES)) u_col (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .ev        (col_if)
    );
  end

  // ------------------------------------------------------------
  // Indication functions per port
  // ------------------------------------------------------------
  logic [NPORT-1:0] f_link;
  logic [NPORT-1:0] f_act;
  logic [NPORT-1:0] f_lact;
  logic [NPORT-1:0] f_fast;
  logic [NPORT-1:0] f_fact;
  logic [NPORT-1:0] f_slow;
  logic [NPORT-1:0] f_sact;
  logic [NPORT-1:0] f_dup;
  logic [NPORT-1:0] f_spd;

  assign f_link = link;
  assign f_act  = act_p & (link | extm);
  assign f_lact = link & ~act_p;
  assign f_fast = link & spd100;
  assign f_fact = link & spd100 & ~act_p;
  assign f_slow = link & ~spd100;
  assign f_sact = link & ~spd100 & ~act_p;
  assign f_dup  = link & (fdx | col_p);
  assign f_spd  = link & spd100;

  // Pin map per function code; index 5 down to 0
  always_comb begin
    ind = '0;
    case (fun_r)
      3'h0: ind = {f_lact[2], f_dup[2], f_spd[2], f_lact[1], f_dup[1], f_spd[1]};
      3'h1: ind = {f_fact[2], f_dup[2], f_sact[2], f_fact[1], f_dup[1], f_sact[1]};
      3'h2: ind = {tx_p[0], f_lact[2], f_spd[2], rx_p[0], f_lact[1], f_spd[1]};
      3'h3: ind = {f_act[2], f_link[2], f_spd[2], f_act[1], f_link[1], f_spd[1]};
      3'h4: ind = {f_act[2], f_link[2], f_dup[2], f_act[1], f_link[1], f_dup[1]};
      3'h5: ind = {f_act[2], f_slow[2], f_fast[2], f_act[1], f_slow[1], f_fast[1]};
      PSLED_FUN_RAW: ind = {txen[0], txen[2], rxdv[2], rxdv[0], txen[1], rxdv[1]};
      default: ind = '0;
    endcase
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pin_out       <= '0;
      o_pin_oe_b      <= '1;
      o_pin_ibuf_en   <= '1;
      o_pin_pullup_en <= '1;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (en_r[i]) begin
          o_pin_ibuf_en[i]   <= 1'b0;
          o_pin_pullup_en[i] <= 1'b0;
          if (fun_r == PSLED_FUN_RAW) begin
            o_pin_out[i]  <= ind[i] & ~dis_r;
            o_pin_oe_b[i] <= 1'b0;
          end else begin
            o_pin_out[i]  <= ~polarity_r[i];
            o_pin_oe_b[i] <= ~(ind[i] & ~dis_r);
          end
        end else begin
          o_pin_ibuf_en[i]   <= ~gpio_oe_r[i];
          o_pin_pullup_en[i] <= 1'b1;
          // Open-drain GPIO drives only a low
          if (gpio_oe_r[i]) begin
            o_pin_out[i]  <= gpio_data_r[i];
            o_pin_oe_b[i] <= ~(gpio_buf_r[i] | ~gpio_data_r[i]);
          end else begin
            o_pin_out[i]  <= 1'b0;
            o_pin_oe_b[i] <= 1'b1;
          end
        end
      end
    end
  end

endmodule

/* File: psled_chk.sv */
// Checker: config shadow from the bus and pin relations of the LED driver
`timescale 1ns/1ps
module psled_chk
  import psled_pkg::*;
#(
  parameter int STRETCH_CYCLES = PSLED_STRETCH_CYC
) (
  // Clock, reset and bus
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  // Straps and port status
  input wire logic [2:0]  i_function_select_strap,
  input wire logic [5:0]  i_pin_enable_strap,
  input wire logic [5:0]  i_polarity_strap,
  input wire logic [2:0]  i_link_up,
  input wire logic [2:0]  i_speed_100,
  input wire logic [2:0]  i_tx_en,
  // Pins
  input wire logic [5:0]  o_pin_out,
  input wire logic [5:0]  o_pin_oe_b,
  input wire logic [5:0]  o_pin_ibuf_en,
  input wire logic [5:0]  o_pin_pullup_en
);
  logic        first_r, wr_r, dis_r;
  logic [11:0] wa_r;
  logic [2:0]  fun_r;
  logic [5:0]  en_r, pol_r;
  int          run_r, gap_r;
  // ----
  // Shadow of the configuration
  // ----
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      first_r <= 1'b1;
      wr_r    <= 1'b0;
      wa_r    <= 12'h000;
      fun_r   <= 3'h0;
      en_r    <= 6'h00;
      pol_r   <= 6'h00;
      dis_r   <= 1'b0;
    end else begin
      first_r <= 1'b0;
      wr_r    <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
      wa_r    <= i_haddr[11:0];
      if (first_r) begin
        fun_r <= i_function_select_strap;
        en_r  <= i_pin_enable_strap;
        pol_r <= i_polarity_strap;
      end
      if (wr_r && wa_r == PSLED_LED_CONFIG_ADDR) begin
        fun_r <= i_hwdata[10:8];
        en_r  <= i_hwdata[5:0];
      end
      if (wr_r && wa_r == PSLED_CONTROL_ADDR) dis_r <= i_hwdata[0];
    end
  end
  // Drive and idle run lengths of pin 5
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      run_r <= 0;
      gap_r <= STRETCH_CYCLES;
    end else begin
      run_r <= o_pin_oe_b[5] ? 0 : run_r + 1;
      if (!o_pin_oe_b[5] && fun_r == 3'h2) gap_r <= 0;
      else if (gap_r < STRETCH_CYCLES) gap_r <= gap_r + 1;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence tx_mode_s;
    (fun_r == 3'h2 && en_r[5] && !dis_r)[*3];
  endsequence
  ibuf_off_a: assert property (((o_pin_ibuf_en | o_pin_pullup_en) & $past(en_r)) == 6'h00)
    else $error("input buffer or pull-up on at LED pin");
  raw_push_a: assert property ((fun_r == PSLED_FUN_RAW && en_r[5] && !dis_r && i_tx_en[0])[*4]
    |=> (!o_pin_oe_b[5] && o_pin_out[5])) else $error("raw pin not driven high");
  dis_raw_a: assert property ((fun_r == PSLED_FUN_RAW && en_r[5] && dis_r)[*2]
    |=> (!o_pin_oe_b[5] && !o_pin_out[5])) else $error("disabled push-pull pin not low");
  dis_od_a: assert property ((fun_r != PSLED_FUN_RAW && en_r[0] && dis_r)[*2]
    |=> o_pin_oe_b[0]) else $error("disabled open-drain pin driven");
  pulse_len_a: assert property (tx_mode_s ##0 $rose(o_pin_oe_b[5])
    |-> run_r == STRETCH_CYCLES) else $error("stretched pulse length wrong");
  recover_min_a: assert property (tx_mode_s ##0 $fell(o_pin_oe_b[5])
    |-> gap_r >= STRETCH_CYCLES) else $error("recovery time too short");
  link_on_a: assert property ((fun_r == 3'h3 && en_r[4] && !dis_r && i_link_up[2])[*4]
    |=> (!o_pin_oe_b[4] && o_pin_out[4] == !pol_r[4])) else $error("link pin not active");
  link_off_a: assert property ((fun_r == 3'h3 && en_r[4] && !i_link_up[2])[*4]
    |=> o_pin_oe_b[4]) else $error("link pin driven without link");
  speed_on_a: assert property ((fun_r == 3'h3 && en_r[3] && !dis_r && i_link_up[2]
    && i_speed_100[2])[*4] |=> (!o_pin_oe_b[3] && o_pin_out[3] == !pol_r[3]))
    else $error("speed pin not active at 100");
endmodule

/* File: psled_led_board.sv */
// Board model: strap resistors and indicator LEDs on the shared pins
`timescale 1ns/1ps
module psled_led_board (
  // Pins from the block
  input  wire logic [5:0] i_pin_out,
  input  wire logic [5:0] i_pin_oe_b,
  input  wire logic [5:0] i_strap,
  // Wire level and LED state
  output logic      [5:0] o_level,
  output logic      [5:0] o_lit
);
  // Released pin rests at its strap resistor level
  assign o_level = (~i_pin_oe_b & i_pin_out) | (i_pin_oe_b & i_strap);
  assign o_lit   = o_level ^ i_strap;
endmodule

/* File: tb.sv */
// Testbench: bus-driven scenarios for the port status LED driver
`timescale 1ns/1ps
module tb;
  import psled_pkg::*;
  localparam int         SC  = 8;
  localparam logic [5:0] POL = 6'h24;
  logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  lnk = 3'h0, spd = 3'h0, fdx = 3'h0, ext = 3'h0;
  logic [2:0]  ev [3] = '{default: 3'h0};
  logic [5:0]  pout, poe_b, pibuf, ppu, lvl, lit;
  int          fail_count = 0, total_checks = 0, n;
  always #20 clk = ~clk;
  psled_top #(.STRETCH_CYCLES(SC)) u_psled_top (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_function_select_strap(3'h2), .i_pin_enable_strap(6'h3F), .i_polarity_strap(POL),
    .i_link_up(lnk), .i_speed_100(spd), .i_full_duplex(fdx), .i_collision(ev[2]),
    .i_tx_en(ev[0]), .i_rx_dv(ev[1]), .i_ext_mii(ext), .o_pin_out(pout),
    .o_pin_oe_b(poe_b), .o_pin_ibuf_en(pibuf), .o_pin_pullup_en(ppu));
  psled_led_board u_psled_led_board (.i_pin_out(pout), .i_pin_oe_b(poe_b), .i_strap(POL),
    .o_level(lvl), .o_lit(lit));
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_rdy();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask
  // One event, a second one inside recovery, count lit cycles
  task automatic blip(int k, int p, int b, int e);
    int c;
    c = 0;
    settle();
    for (int i = 0; i < 40; i++) begin
      ev[k][p] <= (i == 0 || i == 14);
      @(posedge clk);
      c += lit[b];
    end
    ev[k][p] <= 1'b0;
    settle();
    check("lit cycles", c, e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    bus(0, PSLED_LED_CONFIG_ADDR, 0);
    check("config reset", rd, 32'h0000_023F);
    check("okay resp", hresp, 1'b0);
    check("buffers off", {26'h0, pibuf | ppu}, 0);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'hFFFF_FFFF);
    bus(0, PSLED_LED_CONFIG_ADDR, 0);
    check("config fields", rd, 32'h0000_073F);
    bus(0, 12'h1F0, 0);
    check("unmapped read", rd, 0);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h23F);
    settle();
    $display("test registers done");
    blip(0, 0, 5, SC);
    check("tx released", poe_b[5], 1'b1);
    blip(1, 0, 2, SC);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h33F);
    blip(0, 2, 5, 0);
    ext[2] <= 1'b1;
    blip(1, 2, 5, SC);
    ext[2] <= 1'b0;
    lnk[2] <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      spd[2] <= s[0];
      settle();
      check("link", lit[4], 1'b1);
      check("speed", lit[3], s);
    end
    $display("test stretch and link done");
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h13F);
    blip(0, 2, 5, 40 - SC);
    check("slow at 100", lit[3], 1'b0);
    spd[2] <= 1'b0;
    blip(1, 2, 3, 40 - SC);
    check("fast at 10", lit[5], 1'b0);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h03F);
    blip(0, 2, 5, 40 - SC);
    fdx[2] <= 1'b1;
    settle();
    check("full duplex", lit[4], 1'b1);
    fdx[2] <= 1'b0;
    blip(2, 2, 4, SC);
    lnk[2] <= 1'b0;
    fdx[2] <= 1'b1;
    settle();
    check("no link", {lit[5], lit[4]}, 2'b00);
    lnk[2] <= 1'b1;
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h53F);
    settle();
    check("slow link", {lit[4], lit[3]}, 2'b10);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h43F);
    settle();
    check("duplex code 4", lit[3], 1'b1);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h63F);
    settle();
    check("reserved code", poe_b, 6'h3F);
    $display("test link styles done");
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h73F);
    for (int v = 0; v < 2; v++) begin
      ev[0][0] <= v[0];
      ev[1][1] <= v[0];
      settle();
      check("raw pins", {poe_b[5], lvl[5], lvl[0]}, {1'b0, v[0], v[0]});
    end
    bus(1, PSLED_CONTROL_ADDR, 32'h1);
    settle();
    check("raw disabled", {poe_b[5], pout[5]}, 2'b00);
    ev[0][0] <= 1'b0;
    ev[1][1] <= 1'b0;
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h23F);
    blip(0, 0, 5, 0);
    bus(1, PSLED_LED_CONFIG_ADDR, 32'h23B);
    bus(1, PSLED_CONTROL_ADDR, 32'h0404_0000);
    settle();
    check("gpio pin", {poe_b[2], lvl[2]}, 2'b00);
    $display("test raw and gpio done");
    print_verdict();
  end
endmodule
bind psled_top psled_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_psled_chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .i_function_select_strap(i_function_select_strap), .i_pin_enable_strap(i_pin_enable_strap),
  .i_polarity_strap(i_polarity_strap), .i_link_up(i_link_up), .i_speed_100(i_speed_100),
  .i_tx_en(i_tx_en), .o_pin_out(o_pin_out), .o_pin_oe_b(o_pin_oe_b),
  .o_pin_ibuf_en(o_pin_ibuf_en), .o_pin_pullup_en(o_pin_pullup_en));
